// ---- src/dipc_pkg.sv ----
package dipc_pkg;

   // =========================================================================
   // Register map (byte addresses, one aligned word each).
   // =========================================================================
   localparam int          ADDR_W       = 8;
   localparam logic [7:0]  ADDR_CTRL    = 8'h00;
   localparam logic [7:0]  ADDR_STATUS  = 8'h04;
   localparam logic [7:0]  ADDR_CFG     = 8'h08;

   // =========================================================================
   // Control register fields.
   // =========================================================================
   localparam int          CTRL_DOZE_EN_BIT  = 0;
   localparam int          CTRL_RATIO_LSB    = 4;
   localparam int          RATIO_W           = 3;
   localparam int          CTRL_ROI_BIT      = 8;
   localparam int          CTRL_IDLE_SEL_BIT = 12;

   // =========================================================================
   // Status and configuration register fields.
   // =========================================================================
   localparam int          STAT_STATE_LSB    = 0;
   localparam int          STAT_WAKE_IRQ_BIT = 4;
   localparam int          STAT_WAKE_WDT_BIT = 5;
   localparam int          CFG_CLOCK_OUTPUT_FUNCTION_BIT    = 0;

   // =========================================================================
   // Reset values.
   // =========================================================================
   localparam logic               RST_DOZE_EN  = 1'b0;
   localparam logic [RATIO_W-1:0] RST_RATIO    = 3'h0;
   localparam logic               RST_ROI      = 1'b0;
   localparam logic               RST_IDLE_SEL = 1'b0;
   localparam logic               RST_CLOCK_OUTPUT_FUNCTION   = 1'b0;

   // =========================================================================
   // Doze counter width: the largest ratio code gives 1:2^(2^RATIO_W).
   // =========================================================================
   localparam int          CNT_W = 8;

   // =========================================================================
   // AHB-Lite encodings.
   // =========================================================================
   localparam int          HTRANS_XFER_BIT = 1;
   localparam logic        HRESP_OKAY      = 1'b0;

   typedef enum logic [1:0] {
      DIPC_RUN,
      DIPC_IDLE,
      DIPC_SLEEP
   } dipc_state_e;

endpackage

// ---- src/dipc_doze_counter.sv ----
`timescale 1ns/10ps

module dipc_doze_counter #(
   parameter int RATIO_W = 3,
   parameter int CNT_W   = 8
) (
   input  wire logic               ref_clk,
   input  wire logic               resetn,
   input  wire logic               doze_active,
   input  wire logic [RATIO_W-1:0] ratio_code,
   input  wire logic               restart,
   output logic                    exec_slot
);

   logic [CNT_W-1:0] count_ff;
   logic [CNT_W-1:0] nxt_count;
   logic [CNT_W:0]   span;
   logic [CNT_W:0]   span_m1;
   logic [CNT_W-1:0] limit;

   // =========================================================================
   // Ratio decode and counter next value.
   // =========================================================================
   always_comb begin
      span    = {{CNT_W{1'b0}}, 1'b1} << ({1'b0, ratio_code} + 1'b1);
      span_m1 = span - 1'b1;
      limit   = span_m1[CNT_W-1:0];
      if (restart || !doze_active) begin
         nxt_count = '0;
      // A count left above a smaller new limit wraps at once instead of running to the top.
      end else if (count_ff >= limit) begin
         nxt_count = '0;
      end else begin
         nxt_count = count_ff + 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         count_ff <= '0;
      end else begin
         count_ff <= nxt_count;
      end
   end

   // One executed cycle at count zero, the rest skipped.
   assign exec_slot = !doze_active || (count_ff == '0);

endmodule // dipc_doze_counter

// ---- src/dipc_ahb_capture.sv ----
`timescale 1ns/10ps

module dipc_ahb_capture #(
   parameter int ADDR_W = 8
) (
   input  wire logic              ref_clk,
   input  wire logic              resetn,
   input  wire logic              hsel,
   input  wire logic [ADDR_W-1:0] haddr_lo,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic              hready,
   output logic                   rd_take,
   output logic                   wr_pend_ff,
   output logic [ADDR_W-1:0]      wr_addr_ff
);

   logic              take;
   logic              nxt_wr_pend;
   logic [ADDR_W-1:0] nxt_wr_addr;

   // =========================================================================
   // Address phase capture.
   // =========================================================================
   always_comb begin
      take        = hsel && htrans[dipc_pkg::HTRANS_XFER_BIT] && hready;
      rd_take     = take && !hwrite;
      nxt_wr_pend = take && hwrite;
      nxt_wr_addr = take ? haddr_lo : wr_addr_ff;
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= '0;
      end else begin
         wr_pend_ff <= nxt_wr_pend;
         wr_addr_ff <= nxt_wr_addr;
      end
   end

endmodule // dipc_ahb_capture

// ---- src/dipc_top.sv ----
`timescale 1ns/10ps

module dipc_top (
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   // AHB-Lite slave.
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   // Processor core side.
   input  wire logic        sleep_instr,
   input  wire logic        irq_pending,
   input  wire logic        watchdog_timeout,
   output logic             cpu_exec_en,
   output logic             program_memory_en,
   output logic             cpu_power_en,
   output logic             watchdog_reset_req,
   // Clock tree side.
   output logic             sys_osc_run,
   output logic             sys_periph_clk_en,
   output logic             fast_internal_osc_periph_clk_en,
   output logic             slow_internal_osc_periph_clk_en,
   output logic             secondary_osc_periph_clk_en,
   output logic             clock_output_en
);

   // =========================================================================
   // Declarations.
   // =========================================================================
   logic                              doze_enable_bit_ff;
   logic [dipc_pkg::RATIO_W-1:0]      ratio_ff;
   logic                              recover_full_speed_on_irq_ff;
   logic                              idle_select_ff;
   logic                              clock_output_function_ff;
   logic                              nxt_doze_enable_bit;
   logic [dipc_pkg::RATIO_W-1:0]      nxt_ratio;
   logic                              nxt_recover_full_speed_on_irq;
   logic                              nxt_idle_select;
   logic                              nxt_clock_output_function;

   dipc_pkg::dipc_state_e             state_ff;
   dipc_pkg::dipc_state_e             nxt_state;
   logic                              wake_irq_ff;
   logic                              wake_wdt_ff;
   logic                              nxt_wake_irq;
   logic                              nxt_wake_wdt;
   logic                              watchdog_reset_req_ff;
   logic                              nxt_watchdog_reset_req;

   logic                              sys_osc_run_ff;
   logic                              sys_periph_clk_en_ff;
   logic                              cpu_power_en_ff;
   logic                              clock_output_en_ff;
   logic                              nxt_sys_osc_run;
   logic                              nxt_sys_periph_clk_en;
   logic                              nxt_cpu_power_en;
   logic                              nxt_clock_output_en;

   logic [31:0]                       hrdata_ff;
   logic [31:0]                       nxt_hrdata;

   logic                              rd_take;
   logic                              wr_pend_ff;
   logic [dipc_pkg::ADDR_W-1:0]       wr_addr_ff;
   logic                              wr_ctrl;
   logic                              wr_cfg;
   logic                              asleep;
   logic                              irq_wake;
   logic                              wdt_wake;
   logic                              roi_recover;
   logic                              doze_start;
   logic                              counter_restart;
   logic                              exec_slot;

   // =========================================================================
   // Bus address capture.
   // =========================================================================
   dipc_ahb_capture #(
      .ADDR_W     (dipc_pkg::ADDR_W)
   ) u_capture (
      .ref_clk    (ref_clk),
      .resetn     (resetn),
      .hsel       (hsel),
      .haddr_lo   (haddr[dipc_pkg::ADDR_W-1:0]),
      .htrans     (htrans),
      .hwrite     (hwrite),
      .hready     (hready),
      .rd_take    (rd_take),
      .wr_pend_ff (wr_pend_ff),
      .wr_addr_ff (wr_addr_ff)
   );

   // =========================================================================
   // Wake and mode events.
   // =========================================================================
   always_comb begin
      asleep   = (state_ff != dipc_pkg::DIPC_RUN);
      // An interrupt wakes whatever the global enable is; it wins over a watchdog.
      irq_wake = asleep && irq_pending;
      wdt_wake = asleep && !irq_pending && watchdog_timeout;
      // Only an interrupt out of idle may restore full speed.
      roi_recover = irq_wake && (state_ff == dipc_pkg::DIPC_IDLE)
                    && recover_full_speed_on_irq_ff && doze_enable_bit_ff;
      wr_ctrl  = wr_pend_ff && (wr_addr_ff == dipc_pkg::ADDR_CTRL);
      wr_cfg   = wr_pend_ff && (wr_addr_ff == dipc_pkg::ADDR_CFG);
   end

   // =========================================================================
   // Control and configuration registers.
   // =========================================================================
   always_comb begin
      nxt_doze_enable_bit           = doze_enable_bit_ff;
      nxt_ratio                     = ratio_ff;
      nxt_recover_full_speed_on_irq = recover_full_speed_on_irq_ff;
      nxt_idle_select               = idle_select_ff;
      nxt_clock_output_function     = clock_output_function_ff;
      if (roi_recover) begin
         nxt_doze_enable_bit = 1'b0;
      end
      // A software write in the same cycle takes precedence over recovery.
      if (wr_ctrl) begin
         nxt_doze_enable_bit           = hwdata[dipc_pkg::CTRL_DOZE_EN_BIT];
         nxt_ratio                     =
            hwdata[dipc_pkg::CTRL_RATIO_LSB +: dipc_pkg::RATIO_W];
         nxt_recover_full_speed_on_irq = hwdata[dipc_pkg::CTRL_ROI_BIT];
         nxt_idle_select               = hwdata[dipc_pkg::CTRL_IDLE_SEL_BIT];
      end
      if (wr_cfg) begin
         nxt_clock_output_function = hwdata[dipc_pkg::CFG_CLOCK_OUTPUT_FUNCTION_BIT];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         doze_enable_bit_ff           <= dipc_pkg::RST_DOZE_EN;
         ratio_ff                     <= dipc_pkg::RST_RATIO;
         recover_full_speed_on_irq_ff <= dipc_pkg::RST_ROI;
         idle_select_ff               <= dipc_pkg::RST_IDLE_SEL;
         clock_output_function_ff     <= dipc_pkg::RST_CLOCK_OUTPUT_FUNCTION;
      end else begin
         doze_enable_bit_ff           <= nxt_doze_enable_bit;
         ratio_ff                     <= nxt_ratio;
         recover_full_speed_on_irq_ff <= nxt_recover_full_speed_on_irq;
         idle_select_ff               <= nxt_idle_select;
         clock_output_function_ff     <= nxt_clock_output_function;
      end
   end

   // =========================================================================
   // Power state machine.
   // =========================================================================
   always_comb begin
      nxt_state              = state_ff;
      nxt_wake_irq           = wake_irq_ff;
      nxt_wake_wdt           = wake_wdt_ff;
      nxt_watchdog_reset_req = 1'b0;
      unique case (state_ff)
         dipc_pkg::DIPC_RUN: begin
            // The idle select bit is sampled afresh on every sleep instruction.
            if (sleep_instr) begin
               nxt_state = idle_select_ff ? dipc_pkg::DIPC_IDLE
                                          : dipc_pkg::DIPC_SLEEP;
            end
            nxt_watchdog_reset_req = watchdog_timeout;
         end
         dipc_pkg::DIPC_IDLE,
         dipc_pkg::DIPC_SLEEP: begin
            // A watchdog timeout here never requests a reset.
            if (irq_wake) begin
               nxt_state    = dipc_pkg::DIPC_RUN;
               nxt_wake_irq = 1'b1;
               nxt_wake_wdt = 1'b0;
            end else if (wdt_wake) begin
               nxt_state    = dipc_pkg::DIPC_RUN;
               nxt_wake_irq = 1'b0;
               nxt_wake_wdt = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         state_ff              <= dipc_pkg::DIPC_RUN;
         wake_irq_ff           <= 1'b0;
         wake_wdt_ff           <= 1'b0;
         watchdog_reset_req_ff <= 1'b0;
      end else begin
         state_ff              <= nxt_state;
         wake_irq_ff           <= nxt_wake_irq;
         wake_wdt_ff           <= nxt_wake_wdt;
         watchdog_reset_req_ff <= nxt_watchdog_reset_req;
      end
   end

   // =========================================================================
   // Clock and power enables.
   // =========================================================================
   always_comb begin
      // Doze never touches the oscillator or the peripheral clocks.
      nxt_sys_osc_run       = (nxt_state != dipc_pkg::DIPC_SLEEP);
      nxt_sys_periph_clk_en = (nxt_state != dipc_pkg::DIPC_SLEEP);
      nxt_cpu_power_en      = (nxt_state == dipc_pkg::DIPC_RUN);
      nxt_clock_output_en   = nxt_clock_output_function
                              && (nxt_state != dipc_pkg::DIPC_SLEEP);
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         sys_osc_run_ff       <= 1'b1;
         sys_periph_clk_en_ff <= 1'b1;
         cpu_power_en_ff      <= 1'b1;
         clock_output_en_ff   <= 1'b0;
      end else begin
         sys_osc_run_ff       <= nxt_sys_osc_run;
         sys_periph_clk_en_ff <= nxt_sys_periph_clk_en;
         cpu_power_en_ff      <= nxt_cpu_power_en;
         clock_output_en_ff   <= nxt_clock_output_en;
      end
   end

   // =========================================================================
   // Doze throttling.
   // =========================================================================
   always_comb begin
      doze_start      = nxt_doze_enable_bit && !doze_enable_bit_ff;
      // Restart on entry to doze, on recovery and on any wake, so the first
      // cycle after each of them is an executed one.
      counter_restart = doze_start || roi_recover || irq_wake || wdt_wake;
   end

   dipc_doze_counter #(
      .RATIO_W     (dipc_pkg::RATIO_W),
      .CNT_W       (dipc_pkg::CNT_W)
   ) u_doze (
      .ref_clk     (ref_clk),
      .resetn      (resetn),
      .doze_active (doze_enable_bit_ff),
      .ratio_code  (ratio_ff),
      .restart     (counter_restart),
      .exec_slot   (exec_slot)
   );

   // Code 001 yields 1:4 and code 100 yields 1:32 through the counter decode.
   assign cpu_exec_en       = (state_ff == dipc_pkg::DIPC_RUN) && exec_slot;
   assign program_memory_en = (state_ff == dipc_pkg::DIPC_RUN) && exec_slot;

   // =========================================================================
   // Register read path.
   // =========================================================================
   // The read word is built from next values so that a read right after a
   // write, or across a hardware update, returns the fresh contents.
   always_comb begin
      nxt_hrdata = hrdata_ff;
      if (rd_take) begin
         nxt_hrdata = 32'h0000_0000;
         unique case (haddr[dipc_pkg::ADDR_W-1:0])
            dipc_pkg::ADDR_CTRL: begin
               nxt_hrdata[dipc_pkg::CTRL_DOZE_EN_BIT]  = nxt_doze_enable_bit;
               nxt_hrdata[dipc_pkg::CTRL_RATIO_LSB +: dipc_pkg::RATIO_W] = nxt_ratio;
               nxt_hrdata[dipc_pkg::CTRL_ROI_BIT]      = nxt_recover_full_speed_on_irq;
               nxt_hrdata[dipc_pkg::CTRL_IDLE_SEL_BIT] = nxt_idle_select;
            end
            dipc_pkg::ADDR_STATUS: begin
               nxt_hrdata[dipc_pkg::STAT_STATE_LSB +: $bits(dipc_pkg::dipc_state_e)] = nxt_state;
               nxt_hrdata[dipc_pkg::STAT_WAKE_IRQ_BIT]   = nxt_wake_irq;
               nxt_hrdata[dipc_pkg::STAT_WAKE_WDT_BIT]   = nxt_wake_wdt;
            end
            dipc_pkg::ADDR_CFG: begin
               nxt_hrdata[dipc_pkg::CFG_CLOCK_OUTPUT_FUNCTION_BIT] = nxt_clock_output_function;
            end
            default: begin
               nxt_hrdata = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         hrdata_ff <= 32'h0000_0000;
      end else begin
         hrdata_ff <= nxt_hrdata;
      end
   end

   // =========================================================================
   // Outputs.
   // =========================================================================
   assign hreadyout          = 1'b1;
   assign hresp              = dipc_pkg::HRESP_OKAY;
   assign hrdata             = hrdata_ff;
   assign watchdog_reset_req = watchdog_reset_req_ff;
   assign sys_osc_run        = sys_osc_run_ff;
   assign sys_periph_clk_en  = sys_periph_clk_en_ff;
   assign cpu_power_en       = cpu_power_en_ff;
   assign clock_output_en    = clock_output_en_ff;
   // Internal and secondary oscillator peripherals run in every mode.
   assign fast_internal_osc_periph_clk_en = 1'b1;
   assign slow_internal_osc_periph_clk_en = 1'b1;
   assign secondary_osc_periph_clk_en     = 1'b1;

endmodule // dipc_top

// ---- test/dipc_top_asserts.sv ----
`timescale 1ns/10ps

module dipc_top_asserts (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic sleep_instr,
   input wire logic irq_pending,
   input wire logic watchdog_timeout,
   input wire logic cpu_exec_en,
   input wire logic program_memory_en,
   input wire logic cpu_power_en,
   input wire logic watchdog_reset_req,
   input wire logic sys_osc_run,
   input wire logic sys_periph_clk_en,
   input wire logic fast_internal_osc_periph_clk_en,
   input wire logic slow_internal_osc_periph_clk_en,
   input wire logic secondary_osc_periph_clk_en,
   input wire logic clock_output_en
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // ==========
   // Power state relations.
   sequence s_halted_wake;
      !cpu_power_en && (irq_pending || watchdog_timeout);
   endsequence
   sequence s_sleep_cmd;
      cpu_power_en && sleep_instr;
   endsequence
   a_exec_halted: assert property (!cpu_power_en |-> !cpu_exec_en)
      else $error("cpu runs while halted");
   a_sleep_enter: assert property (s_sleep_cmd |=> !cpu_power_en)
      else $error("sleep command ignored");
   a_wake_up: assert property (s_halted_wake |=> cpu_power_en)
      else $error("no wake");
   a_wdt_no_reset: assert property (!cpu_power_en && watchdog_timeout |=> !watchdog_reset_req)
      else $error("watchdog reset while halted");
   a_wake_exec: assert property ($rose(cpu_power_en) |-> cpu_exec_en)
      else $error("no execution right after wake");
   a_skip_periph: assert property (cpu_power_en && !cpu_exec_en |-> sys_periph_clk_en && sys_osc_run)
      else $error("peripheral clock lost in skipped cycle");
   a_idle_periph: assert property (!cpu_power_en && sys_osc_run |-> sys_periph_clk_en)
      else $error("peripheral clock lost in idle");
   a_alt_osc: assert property (fast_internal_osc_periph_clk_en
      && slow_internal_osc_periph_clk_en && secondary_osc_periph_clk_en)
      else $error("internal oscillator peripheral clock off");
   a_pm_follow: assert property (cpu_exec_en == program_memory_en)
      else $error("program memory enable differs");
   a_clock_output_function_keep: assert property ($fell(cpu_power_en) && sys_osc_run |-> $stable(clock_output_en))
      else $error("clock output changed on idle entry");
   a_sleep_stop: assert property ($fell(sys_osc_run) |-> !sys_periph_clk_en && !cpu_power_en)
      else $error("sleep left clocks running");
endmodule // dipc_top_asserts

bind dipc_top dipc_top_asserts i_asserts (.ref_clk, .resetn, .sleep_instr, .irq_pending,
   .watchdog_timeout, .cpu_exec_en, .program_memory_en, .cpu_power_en, .watchdog_reset_req,
   .sys_osc_run, .sys_periph_clk_en, .fast_internal_osc_periph_clk_en,
   .slow_internal_osc_periph_clk_en, .secondary_osc_periph_clk_en, .clock_output_en);

// ---- test/dipc_core_model.sv ----
`timescale 1ns/10ps

module dipc_core_model (
   input  wire logic ref_clk,
   input  wire logic cpu_power_en,
   output logic      sleep_instr,
   output logic      irq_pending,
   output logic      watchdog_timeout
);
   initial begin
      sleep_instr      = 1'b0;
      irq_pending      = 1'b0;
      watchdog_timeout = 1'b0;
   end
   task automatic sleep;
      sleep_instr <= 1'b1;
      @(posedge ref_clk);
      sleep_instr <= 1'b0;
   endtask
   // The request is held until the core is powered again; no global enable gates it.
   task automatic irq;
      irq_pending <= 1'b1;
      do @(posedge ref_clk); while (cpu_power_en !== 1'b1);
      irq_pending <= 1'b0;
   endtask
   task automatic wdt;
      watchdog_timeout <= 1'b1;
      @(posedge ref_clk);
      watchdog_timeout <= 1'b0;
   endtask
endmodule // dipc_core_model

// ---- test/doze_idle_power_control_test.sv ----
`timescale 1ns/10ps

module doze_idle_power_control_test;
   logic        ref_clk, resetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, q, k, ctl;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        sleep_instr, irq_pending, watchdog_timeout, cpu_exec_en, program_memory_en;
   logic        cpu_power_en, watchdog_reset_req, sys_osc_run, sys_periph_clk_en;
   logic        fo, so, sec, clock_output_en;
   int          checked, fails;
   dipc_top i_dut (.ref_clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hrdata, .hresp, .sleep_instr, .irq_pending,
      .watchdog_timeout, .cpu_exec_en, .program_memory_en, .cpu_power_en, .watchdog_reset_req,
      .sys_osc_run, .sys_periph_clk_en, .fast_internal_osc_periph_clk_en(fo),
      .slow_internal_osc_periph_clk_en(so), .secondary_osc_periph_clk_en(sec), .clock_output_en);
   dipc_core_model i_core (.ref_clk, .cpu_power_en, .sleep_instr, .irq_pending,
      .watchdog_timeout);
   // ==========
   // Bus and check tasks.
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cnt(input int c);
      k = 32'h0;
      repeat (c) begin
         @(posedge ref_clk);
         k = k + {31'h0, cpu_exec_en};
      end
   endtask
   task automatic tally_and_finish;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   initial begin
      #400000;
      fails++;
      tally_and_finish();
   end
   // ==========
   // Scenarios.
   initial begin
      {resetn, hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
      hsize = 3'h2;
      repeat (6) @(posedge ref_clk);
      resetn <= 1'b1;
      bus(8'h0c, 1'b1, 32'hffffffff);
      for (int a = 0; a < 16; a += 4) begin
         bus(8'(a), 1'b0, 32'h0);
         chk("reset read", 32'h0, q);
      end
      chk("okay resp", 32'h0, hresp);
      chk("alt osc clk", 32'h7, {fo, so, sec});
      for (int c = 0; c < 8; c++) begin
         bus(dipc_pkg::ADDR_CTRL, 1'b1, 32'h0);
         bus(dipc_pkg::ADDR_CTRL, 1'b1, 32'h1 | (32'(c) << dipc_pkg::CTRL_RATIO_LSB));
         cnt(1);
         chk("first slot", 32'h1, k);
         cnt((4 << (c + 1)) - 1);
         chk("doze slots", 32'h3, k);
      end
      ctl = 32'h1111;
      bus(dipc_pkg::ADDR_CFG, 1'b1, 32'h1);
      bus(dipc_pkg::ADDR_CTRL, 1'b1, ctl);
      i_core.sleep();
      #1 chk("idle power", 32'h0, cpu_power_en);
      chk("idle clock_output_function", 32'h1, clock_output_en);
      chk("idle periph", 32'h1, sys_periph_clk_en);
      chk("idle exec", 32'h0, {cpu_exec_en, program_memory_en});
      bus(dipc_pkg::ADDR_STATUS, 1'b0, 32'h0);
      chk("idle state", 32'h1, q);
      i_core.irq();
      bus(dipc_pkg::ADDR_STATUS, 1'b0, 32'h0);
      chk("irq status", 32'h10, q);
      bus(dipc_pkg::ADDR_CTRL, 1'b0, 32'h0);
      chk("roi ctrl", ctl & ~32'h1, q);
      cnt(8);
      chk("full speed", 32'h8, k);
      bus(dipc_pkg::ADDR_CTRL, 1'b1, ctl);
      i_core.sleep();
      #1 chk("reidle power", 32'h0, cpu_power_en);
      i_core.wdt();
      #1 chk("wdt reset", 32'h0, watchdog_reset_req);
      chk("wdt wake", 32'h1, cpu_power_en);
      bus(dipc_pkg::ADDR_STATUS, 1'b0, 32'h0);
      chk("wdt status", 32'h20, q);
      bus(dipc_pkg::ADDR_CTRL, 1'b0, 32'h0);
      chk("wdt ctrl", ctl, q);
      bus(dipc_pkg::ADDR_CTRL, 1'b1, 32'h0);
      i_core.sleep();
      #1 chk("sleep osc", 32'h0, {sys_osc_run, sys_periph_clk_en, clock_output_en});
      bus(dipc_pkg::ADDR_STATUS, 1'b0, 32'h0);
      chk("sleep state", 32'h22, q);
      i_core.irq();
      #1 chk("sleep wake", 32'h7, {sys_osc_run, sys_periph_clk_en, clock_output_en});
      i_core.wdt();
      #1 chk("run wdt reset", 32'h1, watchdog_reset_req);
      @(posedge ref_clk);
      tally_and_finish();
   end
endmodule // doze_idle_power_control_test
